//--- design/dscp_pkg.sv
package dscp_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int SCLK_MIN_PERIOD_NS = 50;  // Fastest serial clock, 20 MHz
  // Least half period in clock cycles, rounded up
  localparam int SCLK_HALF_MIN =
    (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int RST_PULSE_NS  = 100;
  localparam int RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] DIV_RESET = 8'h04;

  // ----------------------------------------------------------------------
  // Controller registers on the Wishbone side (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] WB_CMD  = 8'h00;
  localparam logic [7:0] WB_TX   = 8'h04;
  localparam logic [7:0] WB_RX   = 8'h08;
  localparam logic [7:0] WB_STAT = 8'h0C;
  localparam logic [7:0] WB_CFG  = 8'h10;
  localparam logic [7:0] WB_DIV  = 8'h14;
  localparam int CMD_GO      = 0;
  localparam int CMD_RD      = 1;
  localparam int CMD_CNT     = 2;   // Two bits: byte count minus one
  localparam int CMD_PINRST  = 4;
  localparam int CMD_ADDR    = 16;  // Thirteen bits of start address
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_REFUSE = 2;
  localparam int STAT_MIRROR = 4;   // Three bits, same layout as CFG
  localparam int CFG_LINE    = 0;
  localparam int CFG_ORDER   = 1;
  localparam int CFG_LONG    = 2;

  // ----------------------------------------------------------------------
  // Device register map and fields
  // ----------------------------------------------------------------------
  localparam logic [12:0] DEV_PORT_CTRL = 13'h0000;
  localparam logic [12:0] DEV_DATA_PATH = 13'h0002;
  localparam logic [12:0] DEV_VERSION   = 13'h000D;
  localparam logic [12:0] DEV_CAL_SEL   = 13'h000E;
  localparam logic [12:0] DEV_CAL_CTRL  = 13'h000F;
  localparam logic [12:0] DEV_CAL_ADDR  = 13'h0010;
  localparam logic [12:0] DEV_CAL_VALUE = 13'h0011;
  localparam logic [12:0] DEV_TOP_ADDR  = 13'h001F;
  localparam int CTL_LINE_DIR  = 7;
  localparam int CTL_BIT_ORDER = 6;
  localparam int CTL_SOFT_RST  = 5;
  localparam int CTL_LONG_PRE  = 4;
  localparam int CTL_FULL_PD   = 3;
  localparam int CTL_SLEEP     = 2;
  localparam int CTL_MCLK_GATE = 1;
  localparam int CTL_EXT_REF   = 0;
  localparam logic [7:0] CTL_DEFAULT = 8'h80;
  localparam int DP_CODING    = 7;
  localparam int DP_LATCH_POL = 4;
  localparam int DP_SKEW_REMOVAL_STAGE    = 3;
  localparam int DP_CLK_TYPE  = 2;
  localparam int DP_CAL_CLK   = 0;

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  localparam int INSTR_SHORT_BITS = 8;
  localparam int INSTR_LONG_BITS  = 16;
  localparam int BYTE_BITS        = 8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_TRAIL,
    ST_GAP,
    ST_RPULSE,
    ST_RGAP
  } dscp_state_t;

endpackage

//--- design/dscp_sync2.sv
`timescale 1ns/100ps
module dscp_sync2 #(
  parameter int W = 2
) (
  input  logic         ref_clk_i,
  input  logic         rst_b_i,
  input  logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] q_q;

  // Two flops; only the second is read outside
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta_q <= '0;
      q_q    <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_q    <= meta_q;
    end
  end

  assign q_o = q_q;

endmodule

//--- design/dscp_tick_gen.sv
`timescale 1ns/100ps
module dscp_tick_gen #(
  parameter int W = 8
) (
  input  logic         ref_clk_i,
  input  logic         rst_b_i,
  input  logic         run_i,
  input  logic [W-1:0] half_i,
  output logic         tick_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  // One pulse per half period; restarts whenever run drops
  always_comb
  begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (!run_i)
      cnt_d = '0;
    else if (cnt_q >= half_i - W'(1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
    else
      cnt_d = cnt_q + W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

//--- design/dscp_host.sv
// Functional notes
// - Instruction bit seven: one reads, zero writes.
// - Bits six, five give one to four bytes.
// - Serial clock never faster than 20 MHz.
// - Drive on falling edge, sample on rising.
// - Select stays low for the whole frame.
// - Bit order follows control bit six, MSB default.
// - New port setup applies from next bit.
// - Use single-byte writes for port setup.
// - Line direction bit: one three-wire, default.
// - Long preamble: two bytes, thirteen address bits.
// - Instruction uses the first rising edges.
// - Reset pin pulse restarts at instruction phase.
`timescale 1ns/100ps
module dscp_host (
  input  logic        ref_clk_i,
  input  logic        rst_b_i,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic        sclk_o,
  output logic        port_select_n_o,
  input  logic        sdio_i,
  output logic        sdio_o,
  output logic        sdio_oe_n_o,
  input  logic        sdo_i,
  output logic        port_reset_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dscp_pkg::dscp_state_t state_q, state_d;
  logic        sclk_q, sclk_d, sel_n_q, sel_n_d, sdo_q, sdo_d;
  logic        oe_n_q, oe_n_d, prst_q, prst_d, ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d, tx_q, tx_d, rx_q, rx_d;
  logic [7:0]  div_q, div_d, rcnt_q, rcnt_d, half_eff;
  logic        cmd_rd_q, cmd_rd_d, lng_q, lng_d;
  logic [1:0]  cmd_cnt_q, cmd_cnt_d, byte_q, byte_d, nx_byte;
  logic [12:0] cmd_addr_q, cmd_addr_d, cur_addr, new_addr;
  logic        line_q, line_d, order_q, order_d, long_q, long_d;
  logic        done_q, done_d, refused_q, refused_d;
  logic        isinst_q, isinst_d, nx_inst;
  logic [3:0]  bit_q, bit_d, nx_bit, iw_last;
  logic        tick, wb_req, wb_wr, cmd_wr, conflict, last_bit, reg0_hit;
  logic [1:0]  pin_s, new_cnt;
  logic [15:0] iword;
  logic [31:0] cmd_word;
  logic [7:0]  cur_tx_byte;
  logic        rx_bit;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Merge a write under the Wishbone byte selects
  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // Wire bit for a frame position under the present bit order
  function automatic logic frame_bit(input logic        inst,
                                     input logic [3:0]  bitn,
                                     input logic [1:0]  byt,
                                     input logic        lsb,
                                     input logic [3:0]  wlast,
                                     input logic [15:0] iw,
                                     input logic [31:0] tx);
    logic [3:0] idx;
    logic [2:0] bidx;
    idx  = lsb ? bitn : wlast - bitn;
    bidx = lsb ? bitn[2:0] : 3'(dscp_pkg::BYTE_BITS - 1) - bitn[2:0];
    if (inst)
      return iw[idx];
    return tx[{byt, bidx}];
  endfunction

  // Pin inputs cross into the clock domain first
  dscp_sync2 #(.W(2)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({sdio_i, sdo_i}),
    .q_o       (pin_s)
  );

  // Never shorter than the 20 MHz half period
  assign half_eff = (div_q < 8'(dscp_pkg::SCLK_HALF_MIN)) ?
                    8'(dscp_pkg::SCLK_HALF_MIN) : div_q;

  dscp_tick_gen #(.W(8)) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .run_i     (state_q != dscp_pkg::ST_IDLE),
    .half_i    (half_eff),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------------
  // Decode of the command write and the present frame position
  // ----------------------------------------------------------------------
  assign wb_req   = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr    = wb_req & wb_we_i;
  assign cmd_wr   = wb_wr & (wb_adr_i == dscp_pkg::WB_CMD) & wb_sel_i[0];
  assign cmd_word = merge_sel(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign new_cnt  = cmd_word[dscp_pkg::CMD_CNT +: 2];
  assign new_addr = cmd_word[dscp_pkg::CMD_ADDR +: 13];
  // Multibyte write that would reach the control register
  assign conflict = ~cmd_word[dscp_pkg::CMD_RD] & (new_cnt != 2'h0) &
                    (order_q ? (new_addr == dscp_pkg::DEV_PORT_CTRL)
                             : (new_addr <= 13'(new_cnt)));
  assign iw_last  = lng_q ? 4'(dscp_pkg::INSTR_LONG_BITS - 1)
                          : 4'(dscp_pkg::INSTR_SHORT_BITS - 1);
  // Read flag, byte count, then address
  assign iword    = lng_q ? {cmd_rd_q, cmd_cnt_q, cmd_addr_q}
                          : {8'h00, cmd_rd_q, cmd_cnt_q, cmd_addr_q[4:0]};
  assign last_bit = ~isinst_q & (bit_q == 4'(dscp_pkg::BYTE_BITS - 1));
  // Address the device uses for this data byte
  assign cur_addr = order_q ? cmd_addr_q + 13'(byte_q)
                            : cmd_addr_q - 13'(byte_q);
  assign reg0_hit = ~cmd_rd_q & (cur_addr == dscp_pkg::DEV_PORT_CTRL);
  assign cur_tx_byte = tx_q[{byte_q, 3'h0} +: 8];
  // Four-wire reads come back on the separate output pin
  assign rx_bit   = line_q ? pin_s[1] : pin_s[0];

  // Next position after a falling edge; instruction first
  always_comb
  begin
    nx_inst = isinst_q;
    nx_bit  = bit_q + 4'h1;
    nx_byte = byte_q;
    if (isinst_q && bit_q == iw_last)
    begin
      nx_inst = 1'b0;
      nx_bit  = 4'h0;
    end
    else if (last_bit)
    begin
      nx_bit  = 4'h0;
      nx_byte = byte_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------------
  // Frame sequencer; clock and data pins change only on divider ticks, select falls and the reset pin moves without them
  always_comb
  begin
    state_d = state_q;     sclk_d  = sclk_q;     sel_n_d = sel_n_q;
    sdo_d   = sdo_q;       oe_n_d  = oe_n_q;     prst_d  = prst_q;
    rcnt_d  = rcnt_q;      rx_d    = rx_q;       lng_d   = lng_q;
    cmd_rd_d = cmd_rd_q;   cmd_cnt_d = cmd_cnt_q; cmd_addr_d = cmd_addr_q;
    line_d  = line_q;      order_d = order_q;    long_d  = long_q;
    done_d  = done_q;      refused_d = refused_q;
    isinst_d = isinst_q;   bit_d   = bit_q;      byte_d  = byte_q;
    case (state_q)
      dscp_pkg::ST_IDLE:
      begin
        sclk_d  = 1'b0;
        sel_n_d = 1'b1;
        oe_n_d  = 1'b1;
        if (wb_wr && wb_adr_i == dscp_pkg::WB_CFG && wb_sel_i[0])
        begin
          line_d  = wb_dat_i[dscp_pkg::CFG_LINE];
          order_d = wb_dat_i[dscp_pkg::CFG_ORDER];
          long_d  = wb_dat_i[dscp_pkg::CFG_LONG];
        end
        if (cmd_wr && cmd_word[dscp_pkg::CMD_PINRST])
        begin
          // High then low restarts the device port
          prst_d  = 1'b1;
          rcnt_d  = 8'h00;
          done_d  = 1'b0;
          state_d = dscp_pkg::ST_RPULSE;
        end
        else if (cmd_wr && cmd_word[dscp_pkg::CMD_GO])
        begin
          done_d    = 1'b0;
          refused_d = conflict;
          if (!conflict)
          begin
            cmd_rd_d   = cmd_word[dscp_pkg::CMD_RD];
            cmd_cnt_d  = new_cnt;
            cmd_addr_d = new_addr;
            lng_d      = long_q;
            isinst_d   = 1'b1;
            bit_d      = 4'h0;
            byte_d     = 2'h0;
            sel_n_d    = 1'b0;
            state_d    = dscp_pkg::ST_LEAD;
          end
        end
      end
      dscp_pkg::ST_LEAD:
        if (tick)
        begin
          sdo_d   = frame_bit(isinst_q, bit_q, byte_q, order_q, iw_last,
                              iword, tx_q);
          oe_n_d  = 1'b0;
          state_d = dscp_pkg::ST_SHIFT;
        end
      dscp_pkg::ST_SHIFT:
        if (tick && !sclk_q)
        begin
          sclk_d = 1'b1;
          // Rising edge: the device takes data, we take read data
          if (!isinst_q && cmd_rd_q)
            rx_d[{byte_q, (order_q ? bit_q[2:0]
                 : 3'(dscp_pkg::BYTE_BITS - 1) - bit_q[2:0])}] = rx_bit;
          // Track a control write the moment its last bit lands
          if (last_bit && reg0_hit)
          begin
            line_d  = cur_tx_byte[dscp_pkg::CTL_LINE_DIR];
            order_d = cur_tx_byte[dscp_pkg::CTL_BIT_ORDER];
            long_d  = cur_tx_byte[dscp_pkg::CTL_LONG_PRE];
          end
        end
        else if (tick)
        begin
          sclk_d = 1'b0;
          if (last_bit && byte_q == cmd_cnt_q)
            state_d = dscp_pkg::ST_TRAIL;
          else
          begin
            // Falling edge: launch the next bit
            isinst_d = nx_inst;
            bit_d    = nx_bit;
            byte_d   = nx_byte;
            sdo_d    = frame_bit(nx_inst, nx_bit, nx_byte, order_q,
                                 iw_last, iword, tx_q);
            // Release the shared line for three-wire reads
            oe_n_d   = ~nx_inst & cmd_rd_q & line_q;
          end
        end
      dscp_pkg::ST_TRAIL:
        if (tick)
        begin
          sel_n_d = 1'b1;
          oe_n_d  = 1'b1;
          done_d  = 1'b1;
          state_d = dscp_pkg::ST_GAP;
        end
      dscp_pkg::ST_GAP:
        if (tick)
          state_d = dscp_pkg::ST_IDLE;
      dscp_pkg::ST_RPULSE:
      begin
        rcnt_d = rcnt_q + 8'h01;
        if (rcnt_q == 8'(dscp_pkg::RST_PULSE_CYC - 1))
        begin
          prst_d  = 1'b0;
          state_d = dscp_pkg::ST_RGAP;
        end
      end
      dscp_pkg::ST_RGAP:
        if (tick)
        begin
          done_d  = 1'b1;
          state_d = dscp_pkg::ST_IDLE;
        end
      default:
        state_d = dscp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= dscp_pkg::ST_IDLE; sclk_q <= 1'b0; sel_n_q <= 1'b1;
      sdo_q   <= 1'b0;  oe_n_q  <= 1'b1;  prst_q <= 1'b0;
      rcnt_q  <= 8'h00; rx_q    <= 32'h0000_0000; lng_q <= 1'b0;
      cmd_rd_q <= 1'b0; cmd_cnt_q <= 2'h0; cmd_addr_q <= 13'h0000;
      line_q  <= dscp_pkg::CTL_DEFAULT[dscp_pkg::CTL_LINE_DIR];
      order_q <= dscp_pkg::CTL_DEFAULT[dscp_pkg::CTL_BIT_ORDER];
      long_q  <= dscp_pkg::CTL_DEFAULT[dscp_pkg::CTL_LONG_PRE];
      done_q  <= 1'b0;  refused_q <= 1'b0;
      isinst_q <= 1'b1; bit_q <= 4'h0; byte_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d; sclk_q <= sclk_d; sel_n_q <= sel_n_d;
      sdo_q   <= sdo_d;   oe_n_q <= oe_n_d; prst_q  <= prst_d;
      rcnt_q  <= rcnt_d;  rx_q   <= rx_d;   lng_q   <= lng_d;
      cmd_rd_q <= cmd_rd_d; cmd_cnt_q <= cmd_cnt_d; cmd_addr_q <= cmd_addr_d;
      line_q  <= line_d;  order_q <= order_d; long_q <= long_d;
      done_q  <= done_d;  refused_q <= refused_d;
      isinst_q <= isinst_d; bit_q <= bit_d; byte_q <= byte_d;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  // One wait-free answer a cycle after the strobe; TX frozen while busy
  always_comb
  begin
    ack_d  = wb_req;
    tx_d   = tx_q;
    div_d  = div_q;
    rdat_d = rdat_q;
    if (wb_wr && state_q == dscp_pkg::ST_IDLE && wb_adr_i == dscp_pkg::WB_TX)
      tx_d = merge_sel(tx_q, wb_dat_i, wb_sel_i);
    if (wb_wr && wb_adr_i == dscp_pkg::WB_DIV && wb_sel_i[0])
      div_d = wb_dat_i[7:0];
    if (wb_req && !wb_we_i)
      case (wb_adr_i)
        dscp_pkg::WB_CMD:
          rdat_d = {3'h0, cmd_addr_q, 12'h000, cmd_cnt_q,
                    cmd_rd_q, 1'b0};
        dscp_pkg::WB_TX:   rdat_d = tx_q;
        dscp_pkg::WB_RX:   rdat_d = rx_q;
        dscp_pkg::WB_STAT:
          rdat_d = {25'h0, long_q, order_q, line_q, 1'b0, refused_q,
                    done_q, state_q != dscp_pkg::ST_IDLE};
        dscp_pkg::WB_CFG:  rdat_d = {29'h0, long_q, order_q, line_q};
        dscp_pkg::WB_DIV:  rdat_d = {24'h0, div_q};
        default:           rdat_d = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_q  <= 1'b0;
      tx_q   <= 32'h0000_0000;
      div_q  <= dscp_pkg::DIV_RESET;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= ack_d;
      tx_q   <= tx_d;
      div_q  <= div_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdat_q;
  assign sclk_o          = sclk_q;
  assign port_select_n_o = sel_n_q;
  assign sdio_o          = sdo_q;
  assign sdio_oe_n_o     = oe_n_q;
  assign port_reset_o    = prst_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] stab_q;
  logic [5:0] rises_q, exp_bits;
  // Helper counters: cycles since the clock pin moved, edges per frame
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      stab_q  <= 8'h00;
      rises_q <= 6'h00;
    end
    else
    begin
      stab_q  <= (sclk_d != sclk_q) ? 8'h00
               : (stab_q == 8'hFF) ? stab_q : stab_q + 8'h01;
      rises_q <= sel_n_q ? 6'h00
               : (sclk_d & ~sclk_q) ? rises_q + 6'h01 : rises_q;
    end
  end
  assign exp_bits = (lng_q ? 6'(dscp_pkg::INSTR_LONG_BITS)
                           : 6'(dscp_pkg::INSTR_SHORT_BITS))
                  + 6'(dscp_pkg::BYTE_BITS) * (6'(cmd_cnt_q) + 6'h01);

  a_sclk_half_min: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $changed(sclk_q) |-> $past(stab_q) >= 8'(dscp_pkg::SCLK_HALF_MIN - 1))
    else $error("serial clock half period too short");
  a_data_on_fall: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $changed(sdio_o) |-> !sclk_o)
    else $error("data changed while serial clock high");
  a_select_held: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == dscp_pkg::ST_SHIFT) |-> !port_select_n_o && !port_reset_o)
    else $error("select released inside a frame");
  a_first_bit_rw: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ($past(state_q) == dscp_pkg::ST_LEAD && state_q == dscp_pkg::ST_SHIFT
     && !lng_q && !order_q) |-> sdio_o == cmd_rd_q)
    else $error("first instruction bit is not the read flag");
  a_frame_length: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(port_select_n_o) |-> rises_q == exp_bits)
    else $error("frame edge count does not match instruction");
  a_cfg_tracks: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == dscp_pkg::ST_SHIFT && tick && !sclk_q && last_bit && reg0_hit)
    |=> order_q == $past(cur_tx_byte[dscp_pkg::CTL_BIT_ORDER]))
    else $error("bit order mirror missed a control write");
  a_single_cfg: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == dscp_pkg::ST_IDLE && cmd_wr && cmd_word[dscp_pkg::CMD_GO]
     && !cmd_word[dscp_pkg::CMD_PINRST] && conflict)
    |=> refused_q && state_q == dscp_pkg::ST_IDLE)
    else $error("multibyte control write was not refused");
  a_line_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    (state_q == dscp_pkg::ST_SHIFT && !isinst_q && cmd_rd_q && line_q)
    |-> sdio_oe_n_o)
    else $error("line driven during three-wire read data");
  a_reset_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(port_reset_o) |-> (port_reset_o && port_select_n_o) [*8])
    else $error("reset pin pulse too short or select low");

endmodule

//--- tb/dscp_dev_model.sv
`timescale 1ns/100ps
module dscp_dev_model (
  input  wire logic sclk_i,
  input  wire logic sel_n_i,
  input  wire logic sdio_i,
  input  wire logic rpin_i,
  output logic      dq_o,
  output logic      doe_o
);
  logic [7:0] regs [0:31];
  logic [7:0] sh;
  logic [7:0] ins;
  logic [4:0] adr;
  int         nb;
  // Defaults; version 8'h05 is arbitrary
  task automatic dflt(input logic [7:0] c0);
    foreach (regs[i]) regs[i] = i == 13 ? 8'h05 : i == 17 ? 8'h3F : 8'h00;
    regs[0] = c0;
  endtask
  initial
  begin
    dflt(8'h80);
    {nb, doe_o, dq_o} = '0;
  end
  // Deselect or pin pulse restarts; a partial byte is dropped
  always @(posedge sel_n_i or posedge rpin_i) {nb, doe_o} = '0;
  // Order bit read per bit, so a new setup acts at once
  always @(posedge sclk_i) if (!sel_n_i)
  begin
    sh = regs[0][6] ? {sdio_i, sh[7:1]} : {sh[6:0], sdio_i};
    nb++;
    if (nb == 8) {ins, adr} = {sh, sh[4:0]};
    if (nb > 8 && nb % 8 == 0 && !ins[7] && adr == 0 && sh[5])
      dflt(sh & 8'hDF);
    else if (nb > 8 && nb % 8 == 0 && !ins[7] && adr != 13)
      regs[adr] = sh;
    if (nb > 8 && nb % 8 == 0)
      adr = regs[0][6] ? adr + 5'h01 : adr - 5'h01;
  end
  // Read data launched on falling edges in 3-wire mode
  always @(negedge sclk_i) if (!sel_n_i && nb >= 8 && ins[7] && regs[0][7])
  begin
    doe_o = 1'b1;
    dq_o = regs[0][6] ? regs[adr][nb % 8] : regs[adr][7 - nb % 8];
  end
endmodule

//--- tb/dscp_host_tb_top.sv
`timescale 1ns/100ps
module dscp_host_tb_top;
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, flip = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, st;
  logic        ack, sclk, csn, sdo_h, oen, rpin, dq, doe;
  wire         sdio_w = !oen ? sdo_h : doe ? dq : flip;
  int          error_cnt = 0, checks_done = 0, tno = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  // Released line toggles so a stale level never passes
  always @(posedge ref_clk_i) flip <= ~flip;
  dscp_host dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sclk_o(sclk),
    .port_select_n_o(csn), .sdio_i(sdio_w), .sdio_o(sdo_h),
    .sdio_oe_n_o(oen), .sdo_i(dq), .port_reset_o(rpin));
  dscp_dev_model dev_u (.sclk_i(sclk), .sel_n_i(csn), .sdio_i(sdio_w),
    .rpin_i(rpin), .dq_o(dq), .doe_o(doe));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  // One device frame, waits for done or refused
  task automatic frame(input logic rd, input logic [1:0] c,
                       input logic [12:0] a, input logic [31:0] tx);
    int n;
    wb(1'b1, dscp_pkg::WB_TX, tx);
    wb(1'b1, dscp_pkg::WB_CMD, {3'h0, a, 12'h0, c, rd, 1'b1});
    n = 0;
    do
    begin
      wb(1'b0, dscp_pkg::WB_STAT, 32'h0);
      n++;
    end while ((q[0] !== 1'b0 || q[2:1] === 2'b00) && n < 300);
    if (n >= 300) error_cnt++;
    st = q;
    wb(1'b0, dscp_pkg::WB_RX, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tend();
    tno++;
    $display("test %0d end", tno);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    chk(oen & csn, 1'b1);
    frame(1'b1, 2'd0, 13'h0000, 32'h0);
    chk(q[7:0], 8'h80);
    frame(1'b0, 2'd0, 13'h0002, 32'hA5);
    frame(1'b1, 2'd0, 13'h0002, 32'h0);
    chk(q[7:0], 8'hA5);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    tend();
    // Every byte count, MSB order counts addresses down
    for (int c = 0; c < 4; c++)
    begin
      frame(1'b0, 2'(c), 13'h0014, 32'h04030201);
      chk(dev_u.regs[20 - c], 8'(c + 1));
    end
    frame(1'b1, 2'd1, 13'h0014, 32'h0);
    chk(q[15:0], 16'h0201);
    frame(1'b0, 2'd1, 13'h0001, 32'h0);
    chk(st[2:1], 2'b10);
    frame(1'b0, 2'd0, 13'h000D, 32'hFF);
    frame(1'b1, 2'd0, 13'h000D, 32'h0);
    chk(q[7:0], 8'h05);
    tend();
    frame(1'b0, 2'd0, 13'h0000, 32'hC0);
    chk(st[5], 1'b1);
    frame(1'b0, 2'd1, 13'h0006, 32'h2211);
    chk(dev_u.regs[7], 8'h22);
    frame(1'b1, 2'd1, 13'h0006, 32'h0);
    chk(q[15:0], 16'h2211);
    frame(1'b0, 2'd0, 13'h0000, 32'hE0);
    chk(dev_u.regs[7], 8'h00);
    frame(1'b1, 2'd0, 13'h0000, 32'h0);
    chk(q[7:0], 8'hC0);
    tend();
    wb(1'b1, dscp_pkg::WB_CMD, 32'h10);
    repeat (5) @(posedge ref_clk_i);
    chk(rpin, 1'b1);
    // Commands are ignored until the pulse and its gap are over
    repeat (20) @(posedge ref_clk_i);
    wb(1'b0, dscp_pkg::WB_STAT, 32'h0);
    chk(q[1:0], 2'b10);
    frame(1'b1, 2'd0, 13'h0006, 32'h0);
    chk(q[7:0], 8'h00);
    tend();
    wrap_up();
  end
endmodule
